// ---- verilog/phy_mgmt_indirect_access.sv ----
// Functional notes
// - Each access control write while not busy and not to the virtual PHY address launches one PHY access, nothing else does. Code also needs pstrb[1:0] set.
// - PHY address comes from access control bits 15:11, reset zero.
// - Register index comes from access control bits 10:6, reset zero.
// - Bit 1 is direction: one writes data register to PHY, zero reads.
// - Busy bit 0 is read-only, set on an access control write that launches an access, held during access.
// - Busy clears itself when the PHY access finishes; resets to zero.
// - Read data is invalid until busy clears; device places it in the same cycle that busy clears.
// - Virtual PHY set is never reachable through these registers.
// - Data register bits 15:0 hold 16-bit management data, read/write, reset zero.
// - Data read returns last written value if direction one, PHY data if zero.
//
// Purpose: APB-reached indirect access engine to the internal PHY management registers
// Assumes: PHY side answers each request with a one-cycle done pulse
// Notes: APB answers with no wait states; unmapped addresses read zero with pslverr
//
// The APB interface to the registers is this design's own decision.
`timescale 1ns/1ps
`default_nettype none
`include "phy_mgmt_defines.svh"

module phy_mgmt_indirect_access
    import phy_mgmt_pkg::*;
#(
    parameter logic [4:0] VPHY_ADDR = 5'h00
)
(
    input wire logic clock_i,
    input wire logic rst_b_i,
    input wire logic psel_i,
    input wire logic penable_i,
    input wire logic pwrite_i,
    input wire logic [11:0] paddr_i,
    input wire logic [31:0] pwdata_i,
    input wire logic [3:0] pstrb_i,
    output logic [31:0] prdata_o,
    output logic pready_o,
    output logic pslverr_o,
    output mgmt_req_t mgmt_req_o,
    input wire mgmt_rsp_t mgmt_rsp_i
);
    eng_state_t state_q;
    eng_state_t state_d;
    logic [4:0] phy_addr_q;
    logic [4:0] reg_index_q;
    logic dir_q;
    logic busy_q;
    logic [15:0] wr_data_q;
    logic [15:0] rd_data_q;
    logic [31:0] prdata_q;
    logic pslverr_q;
    logic pready_q;
    mgmt_req_t req_q;

    wire logic setup = psel_i && !penable_i;
    // Writes land at the access edge, where the master sees pready high
    wire logic access = psel_i && penable_i;
    wire logic sel_data = paddr_i == `OFS_PHY_MGMT_DATA;
    wire logic sel_acc = paddr_i == `OFS_PHY_MGMT_ACCESS_CONTROL;
    wire logic mapped = sel_data || sel_acc;
    wire logic lo_lanes = pstrb_i[1] && pstrb_i[0];
    wire logic wr_data = access && pwrite_i && sel_data && lo_lanes;
    // Late writes are dropped so an access in flight is never restarted
    wire logic wr_acc = access && pwrite_i && sel_acc && lo_lanes && !busy_q;
    // Same address as the virtual PHY never reaches the real PHY sets
    wire logic is_vphy = pwdata_i[`ACC_PHY_ADDR_HI:`ACC_PHY_ADDR_LO] == VPHY_ADDR;
    wire logic launch = wr_acc && !is_vphy;
    wire logic [15:0] data_view = dir_q ? wr_data_q : rd_data_q;
    wire logic [31:0] acc_view = {16'h0000, phy_addr_q, reg_index_q, 4'h0, dir_q, busy_q};
    wire logic [31:0] rd_mux = sel_data ? {16'h0000, data_view} : (sel_acc ? acc_view : 32'h0);

    always_comb
    begin
        state_d = state_q;
        case (state_q)
            ST_IDLE:
            begin
                if (launch)
                    state_d = ST_REQ;
            end
            ST_REQ: state_d = ST_WAIT;
            ST_WAIT:
            begin
                if (mgmt_rsp_i.done)
                    state_d = ST_IDLE;
            end
            default: state_d = ST_IDLE;
        endcase
    end

    always_ff @(posedge clock_i or negedge rst_b_i)
    begin
        if (!rst_b_i)
            state_q <= ST_IDLE;
        else
            state_q <= state_d;
    end

    always_ff @(posedge clock_i or negedge rst_b_i)
    begin
        if (!rst_b_i)
        begin
            phy_addr_q <= `RST_FIELD5;
            reg_index_q <= `RST_FIELD5;
            dir_q <= 1'b0;
        end
        else if (wr_acc)
        begin
            phy_addr_q <= pwdata_i[`ACC_PHY_ADDR_HI:`ACC_PHY_ADDR_LO];
            reg_index_q <= pwdata_i[`ACC_REG_INDEX_HI:`ACC_REG_INDEX_LO];
            dir_q <= pwdata_i[`ACC_DIR_BIT];
        end
    end

    always_ff @(posedge clock_i or negedge rst_b_i)
    begin
        if (!rst_b_i)
            busy_q <= 1'b0;
        else if (launch)
            busy_q <= 1'b1;
        else if (state_q == ST_WAIT && mgmt_rsp_i.done)
            busy_q <= 1'b0;
    end

    always_ff @(posedge clock_i or negedge rst_b_i)
    begin
        if (!rst_b_i)
            wr_data_q <= `RST_DATA;
        else if (wr_data)
            wr_data_q <= pwdata_i[15:0];
    end

    // Result lands together with the busy clear
    always_ff @(posedge clock_i or negedge rst_b_i)
    begin
        if (!rst_b_i)
            rd_data_q <= `RST_DATA;
        else if (state_q == ST_WAIT && mgmt_rsp_i.done && !dir_q)
            rd_data_q <= mgmt_rsp_i.rdata;
    end

    always_ff @(posedge clock_i or negedge rst_b_i)
    begin
        if (!rst_b_i)
            req_q <= '0;
        else if (launch)
        begin
            req_q.valid <= 1'b1;
            req_q.write <= pwdata_i[`ACC_DIR_BIT];
            req_q.phy_addr <= pwdata_i[`ACC_PHY_ADDR_HI:`ACC_PHY_ADDR_LO];
            req_q.reg_index <= pwdata_i[`ACC_REG_INDEX_HI:`ACC_REG_INDEX_LO];
            req_q.wdata <= wr_data_q;
        end
        else
            req_q.valid <= 1'b0;
    end

    always_ff @(posedge clock_i or negedge rst_b_i)
    begin
        if (!rst_b_i)
        begin
            prdata_q <= 32'h0;
            pslverr_q <= 1'b0;
        end
        else if (setup)
        begin
            prdata_q <= pwrite_i ? 32'h0 : rd_mux;
            pslverr_q <= !mapped;
        end
    end

    // Ready only in the access phase; no wait states are ever inserted
    always_ff @(posedge clock_i or negedge rst_b_i)
    begin
        if (!rst_b_i)
            pready_q <= 1'b0;
        else
            pready_q <= setup;
    end

    assign pready_o = pready_q;
    assign prdata_o = prdata_q;
    assign pslverr_o = pslverr_q;
    assign mgmt_req_o = req_q;

    a_busy_on_launch: assert property (@(posedge clock_i) disable iff (!rst_b_i)
        launch |=> busy_q && state_q == ST_REQ) else $error("busy not set on launch");
    a_busy_clear: assert property (@(posedge clock_i) disable iff (!rst_b_i)
        state_q == ST_WAIT && mgmt_rsp_i.done |=> !busy_q) else $error("busy stuck");
    a_req_pulse: assert property (@(posedge clock_i) disable iff (!rst_b_i)
        req_q.valid |-> $past(launch)) else $error("request without launch");
    a_no_vphy: assert property (@(posedge clock_i) disable iff (!rst_b_i)
        req_q.valid |-> req_q.phy_addr != VPHY_ADDR) else $error("virtual PHY reached");
    a_busy_ignore: assert property (@(posedge clock_i) disable iff (!rst_b_i)
        busy_q && !$rose(busy_q) |-> $stable(phy_addr_q) && $stable(dir_q)
        && $stable(reg_index_q))
        else $error("fields moved while busy");
    a_read_result: assert property (@(posedge clock_i) disable iff (!rst_b_i)
        $fell(busy_q) && !dir_q |-> rd_data_q == $past(mgmt_rsp_i.rdata))
        else $error("read data late");
    a_addr_field: assert property (@(posedge clock_i) disable iff (!rst_b_i)
        wr_acc |=> phy_addr_q == $past(pwdata_i[15:11]) && reg_index_q == $past(pwdata_i[10:6]))
        else $error("fields not captured");
    a_data_view: assert property (@(posedge clock_i) disable iff (!rst_b_i)
        setup && !pwrite_i && sel_data |=> prdata_o[15:0] ==
        ($past(dir_q) ? $past(wr_data_q) : $past(rd_data_q))
        && prdata_o[31:16] == 16'h0000) else $error("data view wrong");
    a_data_write: assert property (@(posedge clock_i) disable iff (!rst_b_i)
        wr_data |=> wr_data_q == $past(pwdata_i[15:0])) else $error("data not stored");
    a_req_dir: assert property (@(posedge clock_i) disable iff (!rst_b_i)
        req_q.valid |-> req_q.write == dir_q) else $error("direction mismatch");
    a_vphy_no_busy: assert property (@(posedge clock_i) disable iff (!rst_b_i)
        wr_acc && is_vphy |=> !busy_q) else $error("virtual PHY write started access");
    a_req_wdata: assert property (@(posedge clock_i) disable iff (!rst_b_i)
        req_q.valid |-> req_q.wdata == wr_data_q) else $error("request data wrong");
    a_busy_holds: assert property (@(posedge clock_i) disable iff (!rst_b_i)
        busy_q && !(state_q == ST_WAIT && mgmt_rsp_i.done) |=> busy_q)
        else $error("busy dropped early");
    a_idle_quiet: assert property (@(posedge clock_i) disable iff (!rst_b_i)
        !busy_q |-> state_q == ST_IDLE) else $error("engine active while not busy");
    a_read_stable: assert property (@(posedge clock_i) disable iff (!rst_b_i)
        state_q != ST_WAIT || !mgmt_rsp_i.done |=> $stable(rd_data_q))
        else $error("read data moved outside completion");
endmodule
`default_nettype wire

// ---- verilog/phy_mgmt_defines.svh ----
// Purpose: Offsets, field positions and reset values of the PHY management access block
// Assumes: Byte addresses on a 32-bit APB
// Notes: Definitions only
`ifndef PHY_MGMT_DEFINES_SVH
`define PHY_MGMT_DEFINES_SVH
`define OFS_PHY_MGMT_DATA 12'h0A4
`define OFS_PHY_MGMT_ACCESS_CONTROL 12'h0A8
`define ACC_PHY_ADDR_HI 15
`define ACC_PHY_ADDR_LO 11
`define ACC_REG_INDEX_HI 10
`define ACC_REG_INDEX_LO 6
`define ACC_DIR_BIT 1
`define ACC_BUSY_BIT 0
`define RST_DATA 16'h0000
`define RST_FIELD5 5'h00
`endif

// ---- verilog/phy_mgmt_pkg.sv ----
// Purpose: Types for the PHY management access block
// Assumes: Nothing
// Notes: Request and answer carriers toward the internal PHY register sets
package phy_mgmt_pkg;
    typedef enum logic [1:0] {
        ST_IDLE,
        ST_REQ,
        ST_WAIT
    } eng_state_t;

    typedef struct packed {
        logic valid;
        logic write;
        logic [4:0] phy_addr;
        logic [4:0] reg_index;
        logic [15:0] wdata;
    } mgmt_req_t;

    typedef struct packed {
        logic done;
        logic [15:0] rdata;
    } mgmt_rsp_t;
endpackage

// ---- verif/phy_model.sv ----
// Purpose: Stand-in for the internal PHY register sets
// Assumes: One request outstanding, request fields stand until next launch
// Notes: Read data has the PHY address folded in so routing shows
`timescale 1ns/1ps
`default_nettype none
module phy_model
    import phy_mgmt_pkg::*;
(
    input wire logic clock_i,
    input wire logic rst_b_i,
    input wire logic [3:0] delay_i,
    input wire mgmt_req_t req_i,
    output var mgmt_rsp_t rsp_o
);
    logic [15:0] mem_q [32];
    logic [4:0] cnt_q;
    always_ff @(posedge clock_i or negedge rst_b_i)
    begin
        if (!rst_b_i)
        begin
            cnt_q <= 5'h00;
            rsp_o <= '0;
            for (int i = 0; i < 32; i++)
                mem_q[i] <= 16'h0000;
        end
        else
        begin
            rsp_o.done <= 1'b0;
            // Stale data toggles so a late sample is caught
            rsp_o.rdata <= ~rsp_o.rdata;
            if (cnt_q != 5'h00)
                cnt_q <= cnt_q - 5'h01;
            if (req_i.valid)
            begin
                cnt_q <= {1'b0, delay_i} + 5'h01;
                if (req_i.write)
                    mem_q[req_i.reg_index] <= req_i.wdata;
            end
            else if (cnt_q == 5'h01)
                rsp_o <= {1'b1, mem_q[req_i.reg_index] ^ {req_i.phy_addr, 11'h000}};
        end
    end
endmodule
`default_nettype wire

// ---- verif/testbench.sv ----
// Purpose: Self-checking bench of the PHY management access block
// Assumes: Zero-wait APB slave, pstrb held full
// Notes: Busy is polled, never waited for by a fixed count
`timescale 1ns/1ps
`default_nettype none
`include "phy_mgmt_defines.svh"
module testbench
    import phy_mgmt_pkg::*;
;
    logic clock_i = 0, rst_b_i = 0, psel_i = 0, penable_i = 0, pwrite_i = 0;
    logic pready_o, pslverr_o, err;
    logic [11:0] paddr_i = 12'h000;
    logic [31:0] pwdata_i = 32'h0, prdata_o, q;
    logic [3:0] delay = 4'h0;
    mgmt_req_t mgmt_req_o;
    mgmt_rsp_t mgmt_rsp_i;
    int n_mismatch = 0, checked = 0, cycles = 0, pulses = 0;
    logic [4:0] tp [3] = '{5'h03, 5'h1F, 5'h1F};
    logic [4:0] tr [3] = '{5'h05, 5'h05, 5'h1F};
    logic [15:0] tm [3] = '{16'h1234, 16'h1234, 16'h0000};
    phy_mgmt_indirect_access #(.VPHY_ADDR(5'h00)) DUT (.clock_i(clock_i), .rst_b_i(rst_b_i),
        .psel_i(psel_i), .penable_i(penable_i), .pwrite_i(pwrite_i), .paddr_i(paddr_i),
        .pwdata_i(pwdata_i), .pstrb_i(4'hF), .prdata_o(prdata_o), .pready_o(pready_o),
        .pslverr_o(pslverr_o), .mgmt_req_o(mgmt_req_o), .mgmt_rsp_i(mgmt_rsp_i));
    phy_model phy (.clock_i(clock_i), .rst_b_i(rst_b_i), .delay_i(delay),
        .req_i(mgmt_req_o), .rsp_o(mgmt_rsp_i));
    always #25 clock_i = ~clock_i;
    task summarize;
        if (n_mismatch == 0 && checked > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask
    always @(posedge clock_i)
    begin
        cycles++;
        if (mgmt_req_o.valid === 1'b1)
            pulses++;
        if (cycles == 20000)
        begin
            n_mismatch++;
            summarize();
        end
    end
    task chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
        checked++;
        if (seen !== exp)
        begin
            n_mismatch++;
            $display("unexpected %s: expected %h seen %h", name, exp, seen);
        end
    endtask
    task apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
        psel_i <= 1'b1;
        pwrite_i <= wr;
        paddr_i <= a;
        pwdata_i <= d;
        @(posedge clock_i);
        penable_i <= 1'b1;
        @(posedge clock_i);
        while (pready_o !== 1'b1)
            @(posedge clock_i);
        q = prdata_o;
        err = pslverr_o;
        psel_i <= 1'b0;
        penable_i <= 1'b0;
        @(posedge clock_i);
    endtask
    task go(input logic [4:0] phy_a, input logic [4:0] idx, input logic dir);
        apb(1'b1, `OFS_PHY_MGMT_ACCESS_CONTROL, {16'h0, phy_a, idx, 4'h0, dir, 1'b0});
    endtask
    task idle;
        do
            apb(1'b0, `OFS_PHY_MGMT_ACCESS_CONTROL, 32'h0);
        while (q[0] !== 1'b0);
    endtask
    initial
    begin
        repeat (6) @(posedge clock_i);
        rst_b_i <= 1'b1;
        apb(1'b0, `OFS_PHY_MGMT_DATA, 32'h0);
        chk("data reset", q, 32'h0);
        idle();
        chk("access reset", q, 32'h0);
        delay <= 4'hF;
        apb(1'b1, `OFS_PHY_MGMT_DATA, 32'hFFFF1234);
        apb(1'b0, `OFS_PHY_MGMT_DATA, 32'h0);
        chk("data field", q, 32'h0);
        go(5'h03, 5'h05, 1'b1);
        apb(1'b0, `OFS_PHY_MGMT_ACCESS_CONTROL, 32'h0);
        chk("busy set", q, 32'h00001943);
        go(5'h1F, 5'h1F, 1'b0);
        apb(1'b0, `OFS_PHY_MGMT_ACCESS_CONTROL, 32'h0);
        chk("write while busy", q, 32'h00001943);
        idle();
        chk("busy clear", q, 32'h00001942);
        apb(1'b0, `OFS_PHY_MGMT_DATA, 32'h0);
        chk("data after write", q, 32'h1234);
        for (int i = 0; i < 3; i++)
        begin
            delay <= 4'(i * 7);
            go(tp[i], tr[i], 1'b0);
            idle();
            apb(1'b0, `OFS_PHY_MGMT_DATA, 32'h0);
            chk("read data", q, {16'h0, tm[i] ^ {tp[i], 11'h000}});
        end
        go(5'h00, 5'h02, 1'b0);
        apb(1'b0, `OFS_PHY_MGMT_ACCESS_CONTROL, 32'h0);
        chk("virtual phy busy", {31'h0, q[0]}, 32'h0);
        apb(1'b0, 12'h0B0, 32'h0);
        chk("unmapped error", {31'h0, err}, 32'h1);
        repeat (3) @(posedge clock_i);
        chk("launch count", 32'(pulses), 32'h4);
        summarize();
    end
endmodule
`default_nettype wire
